/* File: verilog/crp_pkg.sv */
package crp_pkg;
    // register byte offsets
    localparam logic [3:0] CRP_OFF_CTRL = 4'h0;
    localparam logic [3:0] CRP_OFF_STATUS = 4'h4;
    localparam logic [3:0] CRP_OFF_MASK = 4'h8;
    localparam logic [3:0] CRP_OFF_LEN = 4'hc;
    // check bit positions
    localparam int CRP_B_READSTA = 0;
    localparam int CRP_B_HOPPER = 1;
    localparam int CRP_B_CLUTCH = 2;
    localparam int CRP_B_PUNCHSTA = 3;
    localparam int CRP_B_JAM = 4;
    localparam int CRP_B_RDCMP = 5;
    localparam int CRP_B_PUCMP = 6;
    localparam int CRP_B_OVERRUN = 7;
    localparam int CRP_B_INVCODE = 8;
    localparam int CRP_NCHK = 9;
    localparam logic [CRP_NCHK-1:0] CRP_CHK_RST = 9'h000;
    localparam logic [6:0] CRP_LEN_RST = 7'h00;
    localparam logic [1:0] CRP_RESP_OKAY = 2'b00;
    localparam logic [1:0] CRP_RESP_SLVERR = 2'b10;
    // timing
    localparam int CRP_CLK_MHZ = 20;
    localparam int CRP_RDCMP_US = 100;
    localparam int CRP_RDCMP_CYC = CRP_RDCMP_US * CRP_CLK_MHZ;
    localparam int CRP_CNT_W = 12;
    localparam logic [7:0] CRP_LEN_FULL = 8'h80;
endpackage

/* File: verilog/crp_check_logic.sv */
// Function
// (RULE1) read station check when any read cell dark at feed cam point two
// (RULE2) hopper check when no card registered at read station by point three
// (RULE3) feed clutch check when point one arrives without clutch pick this cycle
// (RULE4) punch station check when punch cell dark at point three
// (RULE5) stacker jam check when jam sensed over the stacker
// (RULE6) read compare error unless read cells hold steady 100 us after emitter edge
// (RULE7) punch compare error when echo pulses differ from expected echo pattern
// (RULE8) overrun check when cycle steal not serviced before next column
// (RULE9) invalid code check on two or more holes in rows 1 to 7
// (RULE10) every check line is active low
// (RULE11) punch length register holds 128 minus column count
// (RULE12) checks stay latched until system reset
`timescale 1ns/100ps
module crp_check_logic (
    input wire logic clk,
    input wire logic rst,
    // feed timing and sensors
    input wire logic feedCycleStart,
    input wire logic feed_cam_point_one,
    input wire logic feed_cam_point_two,
    input wire logic feed_cam_point_three,
    input wire logic clutchPicked,
    input wire logic [11:0] readCellDark,
    input wire logic cardAtReadStation,
    input wire logic punchCellDark,
    input wire logic stackerJam,
    // column data
    input wire logic readEmitter,
    input wire logic punchEcho,
    input wire logic [11:0] punchEchoBits,
    input wire logic [11:0] punchExpected,
    input wire logic columnStrobe,
    input wire logic stealGrant,
    output logic stealReq,
    output logic [6:0] punchColumnsLeft,
    // active low check lines
    output logic [crp_pkg::CRP_NCHK-1:0] checkLine_n,
    output logic irq,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import crp_pkg::*;

    // ------------------------------------------------------------
    // overview
    // ------------------------------------------------------------
    // the block only watches; it never stops the feed itself
    // every detector below produces a one-cycle event bit
    // events feed two places: the latched check lines and the status
    // check lines hold until reset so a fault can still be probed
    // status bits are the software view and clear on a status read
    // the interrupt is a level, high while any unmasked status bit is set
    // a masked event still latches its check line
    // the mask only gates the interrupt, never the latching
    // bit order is shared by check lines, status, mask and the checks word
    // all sensor inputs are taken as already synchronous to clk
    // debouncing of cells and switches is left to the sensor side
    // cam point pulses are expected to last exactly one clock
    // a longer cam pulse simply raises the same event again
    // raising the same event again is harmless because checks are sticky

    // ------------------------------------------------------------
    // feed cycle bookkeeping
    // ------------------------------------------------------------
    // feedCycleStart opens a new cycle and forgets the old one
    // the clutch and card memories look at the current cycle only
    // the start pulse itself already counts as part of the new cycle
    // a pick in the very cycle of point one is still accepted
    // that choice avoids a false clutch check from a late pick
    // the hopper test likewise accepts a card seen at point three
    // without a start pulse the memories keep accumulating
    // so a missing start pulse can hide a clutch fault; known limitation

    // ------------------------------------------------------------
    // read compare timing
    // ------------------------------------------------------------
    // the compare window length is a cycle count from the package
    // it assumes the clock rate named there; change both together
    // the snapshot is taken on the emitter leading edge
    // any change of the dark pattern inside the window flags an error
    // the edge cycle itself is excluded, its pattern is the reference
    // a new edge inside a window restarts it with a new reference
    // so back to back columns never compare against a stale pattern

    // ------------------------------------------------------------
    // cycle steal
    // ------------------------------------------------------------
    // one request may be pending at a time
    // a column strobe raises the request one cycle later
    // a grant clears it; a grant with no request is ignored
    // a second strobe before the grant is the overrun condition
    // a strobe in the grant cycle is served and starts a new request
    // the request is registered so the channel never sees a glitch

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    // checks word: latched checks, active high, read only
    // status word: sticky events, read clears, read only
    // mask word: interrupt enables, read and write
    // punch length: seven bits, read and write
    // writes to read-only or unmapped words answer with an error
    // reads of unmapped words return zero with an error
    // only whole lanes are written; partial lanes are dropped

    // ------------------------------------------------------------
    // feed checks
    // ------------------------------------------------------------
    logic [CRP_NCHK-1:0] chk_ff, nxt_chk;
    logic [CRP_NCHK-1:0] stat_ff, nxt_stat;
    logic [CRP_NCHK-1:0] mask_ff;
    logic clutchSeen_ff, nxt_clutchSeen;
    logic cardSeen_ff, nxt_cardSeen;
    logic [CRP_NCHK-1:0] evt;

    // clutch and card memory per feed cycle; a pick at point one still counts
    assign nxt_clutchSeen = feedCycleStart ? clutchPicked : (clutchSeen_ff | clutchPicked);
    assign nxt_cardSeen = feedCycleStart ? cardAtReadStation
                                         : (cardSeen_ff | cardAtReadStation);

    assign evt[CRP_B_READSTA] = feed_cam_point_two & (|readCellDark); // RULE1
    assign evt[CRP_B_HOPPER] = feed_cam_point_three & ~nxt_cardSeen; // RULE2
    assign evt[CRP_B_CLUTCH] = feed_cam_point_one & ~nxt_clutchSeen; // RULE3
    assign evt[CRP_B_PUNCHSTA] = feed_cam_point_three & punchCellDark; // RULE4
    assign evt[CRP_B_JAM] = stackerJam; // RULE5

    // ------------------------------------------------------------
    // read compare window
    // ------------------------------------------------------------
    logic emitPrev_ff;
    logic [11:0] cellSnap_ff;
    logic [CRP_CNT_W-1:0] winCnt_ff, nxt_winCnt;
    logic emitEdge;
    logic winActive;

    assign emitEdge = readEmitter & ~emitPrev_ff;
    assign winActive = winCnt_ff != '0;
    // a new edge restarts the window from its own snapshot
    assign nxt_winCnt = emitEdge ? CRP_CNT_W'(CRP_RDCMP_CYC)
                      : winActive ? winCnt_ff - 1'b1 : winCnt_ff;
    assign evt[CRP_B_RDCMP] = winActive & ~emitEdge & (readCellDark != cellSnap_ff); // RULE6

    // ------------------------------------------------------------
    // punch echo, hole code and overrun
    // ------------------------------------------------------------
    function automatic logic multiHole(input logic [6:0] rows);
        logic [2:0] n;
        n = '0;
        for (int i = 0; i < 7; i++) begin
            n = n + {2'b00, rows[i]};
        end
        return n >= 3'd2;
    endfunction

    assign evt[CRP_B_PUCMP] = punchEcho & (punchEchoBits != punchExpected); // RULE7
    // rows 1..7 sit in readCellDark[7:1]
    assign evt[CRP_B_INVCODE] = emitEdge & multiHole(readCellDark[7:1]); // RULE9

    logic stealPend_ff, nxt_stealPend;
    // next column while previous steal still pending means overrun
    assign evt[CRP_B_OVERRUN] = columnStrobe & stealPend_ff & ~stealGrant; // RULE8
    assign nxt_stealPend = columnStrobe | (stealPend_ff & ~stealGrant);
    assign stealReq = stealPend_ff;

    // latched checks, cleared only by reset
    assign nxt_chk = chk_ff | evt; // RULE12
    assign checkLine_n = ~chk_ff; // RULE10

    // ------------------------------------------------------------
    // registers and bus
    // ------------------------------------------------------------
    logic [6:0] len_ff;
    logic awHeld_ff, wHeld_ff;
    logic [3:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic bvalid_ff, rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff, bresp_ff;
    logic doWrite, doRead, wrMapped, rdMapped, statRead;
    logic [31:0] rdMux;

    // punch count complement: columns left = 128 - loaded value
    assign punchColumnsLeft = 7'(CRP_LEN_FULL - {1'b0, len_ff}); // RULE11

    assign s_axi_awready = ~awHeld_ff & ~bvalid_ff;
    assign s_axi_wready = ~wHeld_ff & ~bvalid_ff;
    assign doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;
    assign wrMapped = (awAddr_ff == CRP_OFF_MASK) | (awAddr_ff == CRP_OFF_LEN);
    assign s_axi_arready = ~rvalid_ff;
    assign doRead = s_axi_arvalid & ~rvalid_ff;
    assign rdMapped = s_axi_araddr inside {CRP_OFF_CTRL, CRP_OFF_STATUS, CRP_OFF_MASK,
                                           CRP_OFF_LEN};
    assign statRead = doRead & (s_axi_araddr == CRP_OFF_STATUS);
    assign rdMux = (s_axi_araddr == CRP_OFF_CTRL) ? {23'h0, chk_ff}
                 : (s_axi_araddr == CRP_OFF_STATUS) ? {23'h0, stat_ff}
                 : (s_axi_araddr == CRP_OFF_MASK) ? {23'h0, mask_ff}
                 : (s_axi_araddr == CRP_OFF_LEN) ? {25'h0, len_ff} : 32'h0;

    // sticky status: read clears, but a same-cycle event wins
    assign nxt_stat = (statRead ? '0 : stat_ff) | evt;
    assign irq = |(stat_ff & mask_ff);
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // check and sequencing state
    always_ff @(posedge clk) begin
        if (rst) begin
            chk_ff <= CRP_CHK_RST;
            stat_ff <= CRP_CHK_RST;
            clutchSeen_ff <= 1'b0;
            cardSeen_ff <= 1'b0;
            emitPrev_ff <= 1'b0;
            cellSnap_ff <= '0;
            winCnt_ff <= '0;
            stealPend_ff <= 1'b0;
        end else begin
            chk_ff <= nxt_chk;
            stat_ff <= nxt_stat;
            clutchSeen_ff <= nxt_clutchSeen;
            cardSeen_ff <= nxt_cardSeen;
            emitPrev_ff <= readEmitter;
            if (emitEdge) begin
                cellSnap_ff <= readCellDark;
            end
            winCnt_ff <= nxt_winCnt;
            stealPend_ff <= nxt_stealPend;
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= '0;
            wData_ff <= '0;
            wStrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= CRP_RESP_OKAY;
            mask_ff <= CRP_CHK_RST;
            len_ff <= CRP_LEN_RST;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wrMapped ? CRP_RESP_OKAY : CRP_RESP_SLVERR;
                if (awAddr_ff == CRP_OFF_MASK) begin
                    if (wStrb_ff[0]) mask_ff[7:0] <= wData_ff[7:0];
                    if (wStrb_ff[1]) mask_ff[8] <= wData_ff[8];
                end
                if ((awAddr_ff == CRP_OFF_LEN) & wStrb_ff[0]) begin
                    len_ff <= wData_ff[6:0];
                end
            end else if (bvalid_ff & s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel, one cycle after address
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= CRP_RESP_OKAY;
        end else if (doRead) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rdMux;
            rresp_ff <= rdMapped ? CRP_RESP_OKAY : CRP_RESP_SLVERR;
        end else if (rvalid_ff & s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

/* File: test/crp_check_logic_checker.sv */
`timescale 1ns/100ps
module crp_check_logic_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic feed_cam_point_two,
    input wire logic feed_cam_point_three,
    input wire logic [11:0] readCellDark,
    input wire logic punchCellDark,
    input wire logic stackerJam,
    input wire logic readEmitter,
    input wire logic columnStrobe,
    input wire logic stealGrant,
    input wire logic stealReq,
    input wire logic [crp_pkg::CRP_NCHK-1:0] checkLine_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // both halves of a write taken on one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_readsta_set: assert property (
        feed_cam_point_two && |readCellDark |=> !checkLine_n[0]
    ) else $error("read station check missing");
    a_punchsta_set: assert property (
        feed_cam_point_three && punchCellDark |=> !checkLine_n[3]
    ) else $error("punch station check missing");
    a_jam_set: assert property (
        stackerJam |=> !checkLine_n[4]
    ) else $error("stacker jam check missing");
    a_invcode_set: assert property (
        $rose(readEmitter) && $countones(readCellDark[7:1]) > 1 |=> !checkLine_n[8]
    ) else $error("invalid code check missing");
    a_overrun_set: assert property (
        columnStrobe && stealReq && !stealGrant |=> !checkLine_n[7]
    ) else $error("overrun check missing");
    a_steal_raise: assert property (
        columnStrobe && !stealGrant |=> stealReq
    ) else $error("steal request not raised");
    // a check line may only fall while reset is away
    a_check_latch: assert property (
        1'b1 |=> !(|(checkLine_n & ~$past(checkLine_n)))
    ) else $error("check line released");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    ) else $error("read answer late");
    a_wr_answer: assert property (
        s_wr_taken |-> ##[1:2] s_axi_bvalid
    ) else $error("write answer late");
endmodule

/* File: test/crp_chan_model.sv */
`timescale 1ns/100ps
module crp_chan_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stealReq,
    input wire logic slow,
    output logic stealGrant
);
    logic [3:0] waitCnt_ff;
    // slow mode grants late enough that a second column overruns
    always @(posedge clk) begin
        stealGrant <= 1'b0;
        if (rst || !stealReq || stealGrant) begin
            waitCnt_ff <= 4'h0;
        end else if (waitCnt_ff == (slow ? 4'hf : 4'h1)) begin
            stealGrant <= 1'b1;
        end else begin
            waitCnt_ff <= waitCnt_ff + 4'h1;
        end
    end
endmodule

/* File: test/crp_tb.sv */
`timescale 1ns/100ps
module tb;
    import crp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, feedCycleStart = 1'b0, clutchPicked = 1'b0;
    logic feed_cam_point_one = 1'b0, feed_cam_point_two = 1'b0, feed_cam_point_three = 1'b0;
    logic cardAtReadStation = 1'b0, punchCellDark = 1'b0, stackerJam = 1'b0;
    logic readEmitter = 1'b0, punchEcho = 1'b0, columnStrobe = 1'b0, slow = 1'b0;
    logic stealGrant, stealReq, irq, tA, tW, fin;
    logic [11:0] readCellDark = 12'h000, punchEchoBits = 12'h010, punchExpected = 12'h000;
    logic [6:0] punchColumnsLeft;
    logic [8:0] checkLine_n;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int bad_count = 0;
    int checks = 0;
    always #25 clk = ~clk;
    crp_check_logic dut_u (.*);
    crp_chan_model chan_u (.*);
    task automatic final_report;
        $display("Checks %0d, errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus transfer; ready sampled mid-cycle so the release lands on the taking edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(negedge clk);
            fin = wr ? s_axi_bvalid : s_axi_rvalid;
            tA = wr ? s_axi_awready : s_axi_arready;
            tW = s_axi_wready;
            rd = s_axi_rdata;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge clk);
            if (tA) begin
                {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            end
            if (tW) begin
                s_axi_wvalid <= 1'b0;
            end
            n++;
        end while (!fin && n < 99);
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (!fin) begin
            bad_count++;
            final_report();
        end
        @(negedge clk);
    endtask
    // one column serviced in time: request rises, then clears, no overrun
    task automatic steal_ok;
        @(posedge clk);
        columnStrobe <= 1'b1;
        @(posedge clk);
        columnStrobe <= 1'b0;
        @(negedge clk);
        chk(stealReq, 1'b1);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({stealReq, checkLine_n}, 10'h1ff);
    endtask
    // fire check source k (k 8 also fires the read compare); lines 0..k must read low, the rest high
    task automatic ev(input int k);
        logic [8:0] e;
        e = ~((9'h002 << k) - 9'h001);
        @(posedge clk);
        readCellDark <= (k == 0) ? 12'h002 : ((k == 8) ? 12'h006 : 12'h000);
        {feed_cam_point_one, feed_cam_point_two, feed_cam_point_three} <=
            {k == 2, k == 0, k == 1 || k == 3};
        {punchCellDark, stackerJam, punchEcho, columnStrobe, readEmitter, cardAtReadStation} <=
            {k == 3, k == 4, k == 6, k == 7, k == 5 || k == 8, k > 2};
        @(posedge clk);
        {feed_cam_point_one, feed_cam_point_two, feed_cam_point_three} <= 3'h0;
        {stackerJam, punchEcho} <= 2'h0;
        readCellDark <= (k == 5) ? 12'h001 : 12'h000;
        @(posedge clk);
        {columnStrobe, readEmitter} <= 2'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({irq, checkLine_n}, {1'b1, e});
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({irq, punchColumnsLeft, checkLine_n}, 17'h001ff);
        bus(1'b1, CRP_OFF_LEN, 32'h0000_0030);
        chk({rsp, punchColumnsLeft}, {CRP_RESP_OKAY, 7'h50});
        bus(1'b0, CRP_OFF_LEN, 32'h0);
        chk(rd, 32'h0000_0030);
        bus(1'b1, CRP_OFF_CTRL, 32'h0000_01ff);
        chk(rsp, CRP_RESP_SLVERR);
        bus(1'b1, CRP_OFF_MASK, 32'h0000_01ff);
        steal_ok();
        slow = 1'b1;
        for (int k = 0; k < CRP_NCHK; k++) ev(k);
        // let the last compare window expire so status stays clear after its read
        repeat (CRP_RDCMP_CYC + 4) @(posedge clk);
        bus(1'b1, CRP_OFF_MASK, 32'h0);
        chk(irq, 1'b0);
        bus(1'b1, CRP_OFF_MASK, 32'h0000_01ff);
        bus(1'b0, CRP_OFF_STATUS, 32'h0);
        chk({irq, rd}, 33'h0000_001ff);
        bus(1'b0, CRP_OFF_STATUS, 32'h0);
        chk({irq, rd}, 33'h0);
        bus(1'b0, CRP_OFF_CTRL, 32'h0);
        chk({checkLine_n, rd}, {9'h000, 32'h0000_01ff});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({punchColumnsLeft, checkLine_n}, 16'h01ff);
        final_report();
    end
endmodule
bind crp_check_logic crp_check_logic_checker chk_u (.*);
